// ### hw/sdrs_cmd.sv
// Diagnostic-results, release and sense-request handling with a Wishbone register port
`include "sdrs_regs.svh"

module sdrs_cmd (
	input  wire logic                 clk_i,       // 100 MHz clock
	input  wire logic                 rst_i,       // Sync reset, high
	input  wire logic                 cyc_i,       // Wishbone cycle
	input  wire logic                 stb_i,       // Wishbone strobe
	input  wire logic                 we_i,        // Wishbone write
	input  wire logic [3:0]           adr_i,       // Byte address
	input  wire logic [3:0]           sel_i,       // Byte enables
	input  wire logic [31:0]          dat_i,       // Write data
	output logic                      ack_o,       // Wishbone ack
	output logic [31:0]               dat_o,       // Read data
	input  wire sdrs_pkg::sdrs_diag_t diag_i,      // Prior send-diagnostic result
	input  wire logic                 chk_set_i,   // Check condition raised
	input  wire sdrs_pkg::sdrs_sense_t chk_sense_i, // Its sense contents
	input  wire logic [2:0]           chk_init_i,  // Initiator that got it
	input  wire sdrs_pkg::sdrs_rsv_t  rsv_set_i,   // Reservation made elsewhere
	input  wire logic                 por_fail_i,  // Power-on verify failed pulse
	input  wire logic                 fatal_i,     // Fatal error during transfer
	output logic                      din_valid_o, // Data In byte valid
	output logic [7:0]                din_data_o,  // Data In byte
	output logic                      din_last_o,  // Final byte of phase
	input  wire logic                 din_ready_i, // Initiator takes byte
	output logic                      cmd_done_o,  // Command finished pulse
	output logic [7:0]                status_o,    // Status byte of last command
	output logic                      reserved_o   // Unit reservation active
);
	import sdrs_pkg::*;

	sdrs_state_t q;
	sdrs_state_t d;

	function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
		return (a < b) ? a : b;
	endfunction

	function automatic logic [7:0] cdb_byte(input logic [47:0] c, input int unsigned k);
		return c[8*k +: 8];
	endfunction

	// Extended format only; older and SCSI-2 layouts differ in bytes 0, 7, 13 and 18 to 21
	function automatic logic [7:0] sense_byte(input sdrs_sense_t s, input logic [15:0] i,
			input logic scsi2);
		logic [7:0] b;
		b = 8'h00;
		unique case (i)
			16'd0: b = {s.valid, `SDRS_ERR_CLASS, 3'h0, s.deferred & scsi2};
			16'd2: b = {4'h0, s.key};
			16'd3: b = s.info[31:24];
			16'd4: b = s.info[23:16];
			16'd5: b = s.info[15:8];
			16'd6: b = s.info[7:0];
			16'd7: b = scsi2 ? `SDRS_ASL_SCSI2 : `SDRS_ASL_CCS;
			16'd12: b = s.asc;
			16'd13: b = scsi2 ? s.ascq : 8'h00;
			16'd18: b = scsi2 ? 8'h00 : s.derr[31:24];
			16'd19: b = scsi2 ? 8'h00 : s.derr[23:16];
			16'd20: b = scsi2 ? 8'h00 : s.derr[15:8];
			16'd21: b = scsi2 ? 8'h00 : s.derr[7:0];
			16'd24: b = s.derr[31:24];
			16'd25: b = s.derr[23:16];
			16'd26: b = s.derr[15:8];
			16'd27: b = s.derr[7:0];
			default: b = 8'h00;
		endcase
		return b;
	endfunction

	function automatic logic [15:0] diag_avail(input sdrs_diag_t g);
		if (g.page == `SDRS_PG_XLAT)
			return 16'd6 + {11'h0, g.n_addr, 3'h0};
		return 16'd6;
	endfunction

	function automatic logic [7:0] diag_byte(input sdrs_diag_t g, input logic [15:0] i);
		logic [15:0] plen;
		logic [63:0] fld;
		logic [15:0] fi;
		logic        sel;
		logic [7:0]  b;
		plen = diag_avail(g) - 16'd4;
		fi   = i - 16'd6;
		sel  = fi[3];
		fld  = g.addr[sel];
		b    = 8'h00;
		if (g.page != `SDRS_PG_XLAT) begin
			unique case (i)
				16'd2: b = 8'(`SDRS_PG_LEN_SUPP >> 8);
				16'd3: b = 8'(`SDRS_PG_LEN_SUPP & 16'h00FF);
				16'd4: b = `SDRS_PG_SUPP;
				16'd5: b = `SDRS_PG_XLAT;
				default: b = 8'h00;
			endcase
		end else begin
			if (g.sfmt == `SDRS_FMT_LBA) begin
				fld = g.reserved_area_flag ? {`SDRS_RESERVED_AREA_FLAG_MARK, 48'h0} : {fld[31:0], 32'h0};
			end
			unique case (i)
				16'd0: b = `SDRS_PG_XLAT;
				// Reserved byte must not fall through to the address fields
				16'd1: b = 8'h00;
				16'd2: b = plen[15:8];
				16'd3: b = plen[7:0];
				16'd4: b = {5'h0, g.sfmt};
				// Alternate sector and track stay 0
				16'd5: b = {g.reserved_area_flag & (g.sfmt == `SDRS_FMT_LBA), 4'h0, g.sfmt};
				default: b = fld[8*(7 - fi[2:0]) +: 8];
			endcase
		end
		return b;
	endfunction

	logic        wb_req;
	logic        wb_wr;
	logic [7:0]  op;
	logic        match;
	logic [15:0] dalloc;
	logic [15:0] savail;
	logic [7:0]  salloc;
	logic [31:0] ctrl_w;

	always_comb begin
		d      = q;
		wb_req = cyc_i && stb_i && !q.ack;
		wb_wr  = cyc_i && stb_i && we_i && q.ack;
		op     = cdb_byte(q.cdb, 0);
		match  = q.single || (q.init == q.sns_own);
		dalloc = {cdb_byte(q.cdb, 3), cdb_byte(q.cdb, 4)};
		salloc = cdb_byte(q.cdb, 4);
		savail = q.scsi2 ? `SDRS_AVAIL_SCSI2 : `SDRS_AVAIL_CCS;
		ctrl_w = {29'h0, q.single, q.scsi2, q.busy};
		d.cdone = 1'b0;

		// Ack one cycle after the request, dropped the cycle after
		d.ack = wb_req;
		if (wb_req) begin
			unique case (adr_i)
				`SDRS_OFS_CTRL: d.rdat = ctrl_w;
				`SDRS_OFS_CDB0: d.rdat = q.cdb[31:0];
				`SDRS_OFS_CDB1: d.rdat = {13'h0, q.init, q.cdb[47:32]};
				`SDRS_OFS_STAT: d.rdat = {16'h0, q.stat, 1'b0, q.ua, q.por, q.rsv,
					q.sns_v, q.vld, q.done, q.busy};
				default: d.rdat = 32'h0;
			endcase
		end

		// Writes land on the edge where the master sees ack
		if (wb_wr && !q.busy) begin
			unique case (adr_i)
				`SDRS_OFS_CTRL: begin
					if (sel_i[0]) begin
						d.scsi2  = dat_i[`SDRS_CTRL_SCSI2];
						d.single = dat_i[`SDRS_CTRL_SINGLE];
					end
				end
				`SDRS_OFS_CDB0: begin
					for (int k = 0; k < 4; k++)
						if (sel_i[k])
							d.cdb[8*k +: 8] = dat_i[8*k +: 8];
				end
				`SDRS_OFS_CDB1: begin
					if (sel_i[0])
						d.cdb[39:32] = dat_i[7:0];
					if (sel_i[1])
						d.cdb[47:40] = dat_i[15:8];
					if (sel_i[2])
						d.init = dat_i[`SDRS_CDB1_INIT +: 3];
				end
				default: ;
			endcase
		end

		unique case (q.st)
			SDRS_IDLE: begin
				if (wb_wr && !q.busy && adr_i == `SDRS_OFS_CTRL && sel_i[0] &&
						dat_i[`SDRS_CTRL_START]) begin
					d.busy     = 1'b1;
					d.done     = 1'b0;
					d.fatal    = 1'b0;
					d.idx      = 16'h0;
					d.cnt      = 16'h0;
					d.stat     = `SDRS_ST_GOOD;
					d.is_sense = 1'b0;
					d.st       = SDRS_XFER;
					if (op == `SDRS_OP_RSENSE) begin
						// Runs whatever the reservation holder
						d.is_sense = 1'b1;
						d.rpt      = (match && q.sns_v) ? q.sns : '0;
						if (q.por)
							d.rpt.key = `SDRS_KEY_HWERR;
						if (salloc == 8'h00)
							d.cnt = q.scsi2 ? 16'h0 : `SDRS_ZERO_CCS;
						else
							d.cnt = min16({8'h0, salloc}, savail);
					end else begin
						if (match)
							d.sns_v = 1'b0;
						if (q.ua) begin
							// Deferred unit attention preempts the command
							d.ua      = 1'b0;
							d.stat    = `SDRS_ST_CHECK;
							d.sns_v   = 1'b1;
							d.sns     = '0;
							d.sns.key = `SDRS_KEY_UATTN;
							d.sns_own = q.init;
						end else if (op == `SDRS_OP_RCVDIAG) begin
							d.cnt = min16(dalloc, diag_avail(diag_i));
						end else if (op == `SDRS_OP_RELEASE) begin
							// Inactive or foreign reservation: GOOD, untouched
							if (q.rsv && q.rsv_own == q.init) begin
								if (!q.cdb[12] && !q.rsv_tp)
									d.rsv = 1'b0;
								else if (q.cdb[12] && q.rsv_tp && q.rsv_tpid == q.cdb[11:9])
									d.rsv = 1'b0;
							end
						end
					end
				end
			end
			SDRS_XFER: begin
				if (fatal_i && q.is_sense)
					d.fatal = 1'b1;
				if (!q.vld || din_ready_i) begin
					if (q.idx < q.cnt) begin
						d.vld  = 1'b1;
						d.dat  = q.is_sense ? sense_byte(q.rpt, q.idx, q.scsi2) : diag_byte(diag_i, q.idx);
						d.last = (q.idx + 16'd1 == q.cnt);
						d.idx  = q.idx + 16'd1;
					end else begin
						d.vld  = 1'b0;
						d.last = 1'b0;
						d.st   = SDRS_FIN;
					end
				end
			end
			SDRS_FIN: begin
				d.busy  = 1'b0;
				d.done  = 1'b1;
				d.cdone = 1'b1;
				d.st    = SDRS_IDLE;
				if (q.is_sense) begin
					// Only a fatal error turns the answer to
					d.stat = (q.fatal || fatal_i) ? `SDRS_ST_CHECK : `SDRS_ST_GOOD;
					if (!(q.fatal || fatal_i)) begin
						if (match)
							d.sns_v = 1'b0;
						if (q.por) begin
							d.por = 1'b0;
							d.ua  = 1'b1;
						end
					end
				end
			end
			default: d.st = SDRS_IDLE;
		endcase

		if (rsv_set_i.set) begin
			d.rsv      = 1'b1;
			d.rsv_own  = rsv_set_i.init;
			d.rsv_tp   = rsv_set_i.tp;
			d.rsv_tpid = rsv_set_i.tpid;
		end
		if (por_fail_i)
			d.por = 1'b1;
		// New check condition wins over a clear in the same cycle
		if (chk_set_i) begin
			d.sns_v   = 1'b1;
			d.sns     = chk_sense_i;
			d.sns_own = chk_init_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q        <= '0;
			q.st     <= SDRS_IDLE;
			q.scsi2  <= `SDRS_CTRL_RST;
			q.single <= `SDRS_CTRL_RST;
		end else begin
			q <= d;
		end
	end

	assign ack_o       = q.ack;
	assign dat_o       = q.rdat;
	assign din_valid_o = q.vld;
	assign din_data_o  = q.dat;
	assign din_last_o  = q.last;
	assign cmd_done_o  = q.cdone;
	assign status_o    = q.stat;
	assign reserved_o  = q.rsv;
endmodule

// ### hw/sdrs_regs.svh
// Register offsets, field positions, opcodes and fixed figures of the command block
`ifndef SDRS_REGS_SVH
`define SDRS_REGS_SVH
`define SDRS_OFS_CTRL      4'h0
`define SDRS_OFS_CDB0      4'h4
`define SDRS_OFS_CDB1      4'h8
`define SDRS_OFS_STAT      4'hC
`define SDRS_CTRL_START    0
`define SDRS_CTRL_SCSI2    1
`define SDRS_CTRL_SINGLE   2
`define SDRS_CDB1_INIT     16
`define SDRS_CTRL_RST      1'b0
`define SDRS_OP_RSENSE     8'h03
`define SDRS_OP_RELEASE    8'h17
`define SDRS_OP_RCVDIAG    8'h1C
`define SDRS_PG_SUPP       8'h00
`define SDRS_PG_XLAT       8'h40
`define SDRS_PG_LEN_SUPP   16'h0002
`define SDRS_FMT_LBA       3'h0
`define SDRS_RESERVED_AREA_FLAG_MARK    16'hFFFF
`define SDRS_ERR_CLASS     3'h7
`define SDRS_ASL_CCS       8'h0E
`define SDRS_ASL_SCSI2     8'h14
`define SDRS_AVAIL_CCS     16'h0016
`define SDRS_AVAIL_SCSI2   16'h001C
`define SDRS_ZERO_CCS      16'h0004
`define SDRS_KEY_HWERR     4'h4
`define SDRS_KEY_UATTN     4'h6
`define SDRS_ST_GOOD       8'h00
`define SDRS_ST_CHECK      8'h02
`endif

// ### hw/sdrs_pkg.sv
// Types shared by the command block and its bench
package sdrs_pkg;
	typedef enum logic [1:0] {SDRS_IDLE, SDRS_XFER, SDRS_FIN} sdrs_st_t;

	typedef struct packed {
		logic        deferred;
		logic        valid;
		logic [3:0]  key;
		logic [31:0] info;
		logic [7:0]  asc;
		logic [7:0]  ascq;
		logic [31:0] derr;
	} sdrs_sense_t;

	typedef struct packed {
		logic [7:0]       page;
		logic [2:0]       sfmt;
		logic             reserved_area_flag;
		logic [1:0]       n_addr;
		logic [1:0][63:0] addr;
	} sdrs_diag_t;

	typedef struct packed {
		logic       set;
		logic [2:0] init;
		logic       tp;
		logic [2:0] tpid;
	} sdrs_rsv_t;

	typedef struct packed {
		sdrs_st_t    st;
		logic        ack;
		logic [31:0] rdat;
		logic        scsi2;
		logic        single;
		logic [47:0] cdb;
		logic [2:0]  init;
		logic        busy;
		logic        done;
		logic        cdone;
		logic [7:0]  stat;
		logic        is_sense;
		logic [15:0] cnt;
		logic [15:0] idx;
		logic        vld;
		logic [7:0]  dat;
		logic        last;
		logic        fatal;
		logic        sns_v;
		sdrs_sense_t sns;
		logic [2:0]  sns_own;
		sdrs_sense_t rpt;
		logic        rsv;
		logic [2:0]  rsv_own;
		logic        rsv_tp;
		logic [2:0]  rsv_tpid;
		logic        por;
		logic        ua;
	} sdrs_state_t;
endpackage

// ### tb/sdrs_cmd_assertions.sv
// Port-level checks on the command block
module sdrs_cmd_assertions (
	input wire logic                clk_i,       // Clock
	input wire logic                rst_i,       // Sync reset
	input wire logic                cyc_i,       // Bus cycle
	input wire logic                stb_i,       // Bus strobe
	input wire logic                we_i,        // Bus write
	input wire logic [3:0]          adr_i,       // Bus address
	input wire logic [31:0]         dat_i,       // Write data
	input wire logic                ack_o,       // Bus ack
	input wire sdrs_pkg::sdrs_rsv_t rsv_set_i,   // Reservation event
	input wire logic                din_valid_o, // Byte valid
	input wire logic [7:0]          din_data_o,  // Byte
	input wire logic                din_last_o,  // Last byte
	input wire logic                din_ready_i, // Byte taken
	input wire logic                cmd_done_o,  // Command end
	input wire logic [7:0]          status_o,    // Status byte
	input wire logic                reserved_o   // Reserved level
);
	timeunit 1ns;
	timeprecision 1ps;
	import sdrs_pkg::*;
	logic [7:0] op_q;
	logic       first_q;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Tracks opcode and first byte so sense bytes can be told apart
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			op_q <= 8'h00;
			first_q <= 1'b0;
		end else begin
			if (cyc_i && stb_i && we_i && ack_o && adr_i == 4'h4)
				op_q <= dat_i[7:0];
			if (cyc_i && stb_i && we_i && ack_o && adr_i == 4'h0 && dat_i[0])
				first_q <= 1'b1;
			else if (din_valid_o && din_ready_i)
				first_q <= 1'b0;
		end
	end
	chk_ack_pulse:
	assert property (ack_o |=> !ack_o) else $error("ack held too long");
	chk_ack_reply:
	assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
	chk_done_pulse:
	assert property (cmd_done_o |=> !cmd_done_o) else $error("done held too long");
	chk_last_end:
	assert property (din_valid_o && din_last_o && din_ready_i |=> !din_valid_o ##[0:1] cmd_done_o)
		else $error("phase not ended after last byte");
	chk_byte_hold:
	assert property (din_valid_o && !din_ready_i |=> din_valid_o && $stable(din_data_o) && $stable(din_last_o))
		else $error("byte changed before taken");
	chk_sense_class:
	assert property (din_valid_o && first_q && op_q == 8'h03 |-> din_data_o[6:1] == 6'h38)
		else $error("sense byte 0 not extended class 7");
	chk_rsv_rise:
	assert property ($rose(reserved_o) |-> $past(rsv_set_i.set)) else $error("reservation from nowhere");
	chk_status_code:
	assert property (cmd_done_o |-> status_o == 8'h00 || status_o == 8'h02) else $error("bad status");
	chk_done_quiet:
	assert property (cmd_done_o |-> !din_valid_o) else $error("byte offered at command end");
endmodule

bind sdrs_cmd sdrs_cmd_assertions i_sdrs_cmd_assertions (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
	.dat_i, .ack_o, .rsv_set_i, .din_valid_o, .din_data_o, .din_last_o, .din_ready_i, .cmd_done_o,
	.status_o, .reserved_o);

// ### tb/sdrs_init_model.sv
// Initiator stand-in taking Data In bytes at full rate or stalling
module sdrs_init_model (
	input  wire logic clk_i,      // Clock
	input  wire logic slow_i,     // Stall every other cycle
	output logic      din_ready_o // Byte accepted
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tog_q = 1'b0;
	always @(posedge clk_i) tog_q <= ~tog_q;
	assign din_ready_o = slow_i ? tog_q : 1'b1;
endmodule

// ### tb/sdrs_cmd_tb_top.sv
// Bench for the diagnostic, release and sense command block
module sdrs_cmd_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import sdrs_pkg::*;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, chk_set_i = 0, por_fail_i = 0, fatal_i = 0;
	logic [3:0] adr_i = 0, sel_i = 4'hF;
	logic [31:0] dat_i = 0, dat_o;
	logic [2:0] chk_init_i = 0;
	sdrs_diag_t diag_i = '0;
	sdrs_sense_t chk_sense_i = '0;
	sdrs_rsv_t rsv_set_i = '0;
	logic ack_o, din_valid_o, din_last_o, din_ready_i, cmd_done_o, reserved_o, slow = 0;
	logic [7:0] din_data_o, status_o;
	logic [7:0] q[$];
	int error_cnt = 0, checks = 0, cyc_n = 0;
	sdrs_cmd i_sdrs_cmd (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .ack_o, .dat_o,
		.diag_i, .chk_set_i, .chk_sense_i, .chk_init_i, .rsv_set_i, .por_fail_i, .fatal_i, .din_valid_o,
		.din_data_o, .din_last_o, .din_ready_i, .cmd_done_o, .status_o, .reserved_o);
	sdrs_init_model i_sdrs_init_model (.clk_i, .slow_i(slow), .din_ready_o(din_ready_i));
	always #5 clk_i = ~clk_i;
	// Ceiling well above the few hundred cycles the tests need
	always @(posedge clk_i) begin
		if (din_valid_o === 1'b1 && din_ready_i === 1'b1)
			q.push_back(din_data_o);
		cyc_n <= cyc_n + 1;
		if (cyc_n == 20000) begin
			error_cnt++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(string name, logic [15:0] got, logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wb(logic w, logic [3:0] a, logic [31:0] d, output logic [31:0] r);
		@(posedge clk_i);
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		r = dat_o;
		cyc_i <= 0;
		stb_i <= 0;
		we_i <= 0;
	endtask
	// Allocation high byte lands in CDB byte 3, low byte in byte 4
	task automatic cmd(logic [7:0] op, logic [7:0] b1, logic [15:0] al, logic [2:0] ini, logic [1:0] md);
		logic [31:0] r;
		q = {};
		wb(1, 4'h4, {al[15:8], 8'h00, b1, op}, r);
		wb(1, 4'h8, {13'h0, ini, 8'h00, al[7:0]}, r);
		// Mode settles first: the start edge decodes with the stored mode
		wb(1, 4'h0, {29'h0, md, 1'b0}, r);
		wb(1, 4'h0, {29'h0, md, 1'b1}, r);
		do @(posedge clk_i); while (cmd_done_o !== 1'b1);
		@(posedge clk_i);
	endtask
	task automatic chkq(logic [7:0] e[$], logic [7:0] st);
		check("length", 16'(q.size()), 16'(e.size()));
		foreach (e[i]) check("byte", {8'h00, q[i]}, {8'h00, e[i]});
		check("status", {8'h00, status_o}, {8'h00, st});
	endtask
	task automatic load(logic [3:0] k, logic [2:0] ini);
		@(posedge clk_i);
		chk_set_i <= 1;
		chk_sense_i <= '{valid: 1'b1, key: k, default: '0};
		chk_init_i <= ini;
		@(posedge clk_i);
		chk_set_i <= 0;
	endtask
	task automatic t_diag();
		logic [7:0] e[$];
		diag_i <= '{page: 8'h00, default: '0};
		cmd(8'h1C, 0, 16'h0100, 0, 0);
		chkq('{8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h40}, 8'h00);
		cmd(8'h1C, 0, 16'h0003, 0, 0);
		chkq('{8'h00, 8'h00, 8'h00}, 8'h00);
		cmd(8'h1C, 0, 16'h0000, 0, 0);
		chkq('{}, 8'h00);
		diag_i <= '{page: 8'h40, sfmt: 3'h0, reserved_area_flag: 1'b1, n_addr: 2'd1, addr: '0};
		cmd(8'h1C, 0, 16'h00FF, 0, 0);
		chkq('{8'h40, 0, 0, 8'h0A, 0, 8'h80, 8'hFF, 8'hFF, 0, 0, 0, 0, 0, 0}, 0);
		diag_i <= '{page: 8'h40, sfmt: 3'h0, reserved_area_flag: 1'b0, n_addr: 2'd1, addr: {64'h0, 64'h99887766A1B2C3D4}};
		cmd(8'h1C, 0, 16'h00FF, 0, 0);
		chkq('{8'h40, 0, 0, 8'h0A, 0, 0, 8'hA1, 8'hB2, 8'hC3, 8'hD4, 0, 0, 0, 0}, 0);
		diag_i <= '{page: 8'h40, sfmt: 3'h5, reserved_area_flag: 1'b0, n_addr: 2'd2,
			addr: {64'h1112131415161718, 64'h0102030405060708}};
		e = '{8'h40, 0, 0, 8'h12, 8'h05, 8'h05};
		for (int i = 1; i <= 8; i++) e.push_back(8'(i));
		for (int i = 1; i <= 8; i++) e.push_back(8'(8'h10 + i));
		slow <= 1;
		cmd(8'h1C, 0, 16'h00FF, 0, 0);
		chkq(e, 0);
		slow <= 0;
		$display("test diag done");
	endtask
	task automatic t_sense();
		load(4'h3, 2);
		cmd(8'h03, 0, 16'h0000, 2, 2'b01);
		chkq('{}, 0);
		load(4'h3, 2);
		cmd(8'h03, 0, 16'h0000, 2, 2'b00);
		chkq('{8'hF0, 0, 8'h03, 0}, 0);
		cmd(8'h03, 0, 16'h0003, 2, 2'b00);
		chkq('{8'h70, 0, 0}, 0);
		slow <= 1;
		cmd(8'h03, 0, 16'h00FF, 2, 2'b01);
		check("count", 16'(q.size()), 16'd28);
		check("addlen", {8'h00, q[7]}, 16'h0014);
		slow <= 0;
		cmd(8'h03, 0, 16'h00FF, 2, 2'b00);
		check("count", 16'(q.size()), 16'd22);
		$display("test sense done");
	endtask
	task automatic t_keep();
		load(4'h3, 2);
		cmd(8'h03, 0, 16'h0003, 5, 2'b00);
		chkq('{8'h70, 0, 0}, 0);
		cmd(8'h03, 0, 16'h0003, 2, 2'b00);
		chkq('{8'hF0, 0, 8'h03}, 0);
		load(4'h3, 2);
		cmd(8'h17, 0, 16'h0000, 2, 2'b00);
		chkq('{}, 0);
		cmd(8'h03, 0, 16'h0003, 2, 2'b00);
		chkq('{8'h70, 0, 0}, 0);
		load(4'h3, 2);
		cmd(8'h03, 0, 16'h0003, 5, 2'b10);
		chkq('{8'hF0, 0, 8'h03}, 0);
		$display("test keep done");
	endtask
	task automatic t_rsv();
		logic [31:0] r;
		@(posedge clk_i);
		rsv_set_i <= '{set: 1'b1, init: 3'h1, tp: 1'b1, tpid: 3'h4};
		@(posedge clk_i);
		rsv_set_i <= '0;
		cmd(8'h03, 0, 16'h0001, 3, 2'b00);
		chkq('{8'h70}, 0);
		cmd(8'h17, 8'h16, 16'h0000, 1, 2'b00);
		check("reserved", {15'h0, reserved_o}, 16'h0001);
		wb(0, 4'hC, 0, r);
		check("stat_rsv", {15'h0, r[4]}, 16'h0001);
		wb(0, 4'h2, 32'hFFFFFFFF, r);
		check("unmapped", r[15:0], 16'h0000);
		cmd(8'h17, 8'h18, 16'h0000, 1, 2'b00);
		check("reserved", {15'h0, reserved_o}, 16'h0000);
		cmd(8'h17, 8'h00, 16'h0000, 1, 2'b00);
		chkq('{}, 0);
		$display("test release done");
	endtask
	task automatic t_por();
		@(posedge clk_i);
		por_fail_i <= 1;
		@(posedge clk_i);
		por_fail_i <= 0;
		cmd(8'h03, 0, 16'h0003, 0, 2'b00);
		check("hw_key", {12'h0, q[2][3:0]}, 16'h0004);
		cmd(8'h17, 0, 16'h0000, 0, 2'b00);
		check("ua_status", {8'h00, status_o}, 16'h0002);
		cmd(8'h03, 0, 16'h0003, 0, 2'b00);
		check("ua_key", {12'h0, q[2][3:0]}, 16'h0006);
		load(4'h3, 2);
		fatal_i <= 1;
		cmd(8'h03, 0, 16'h0003, 2, 2'b00);
		check("fatal", {8'h00, status_o}, 16'h0002);
		fatal_i <= 0;
		$display("test power-on and fatal done");
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 0;
		t_diag();
		t_sense();
		t_keep();
		t_rsv();
		t_por();
		final_report();
	end
endmodule
